//--- core/ams_consts.svh
`ifndef AMS_CONSTS_SVH
`define AMS_CONSTS_SVH
// ==============================
// Clock
`define AMS_CLK_PERIOD_NS 10
// ==============================
// Register offsets (byte addresses)
`define AMS_OFS_SIGNAL_CTRL 7'h00
`define AMS_OFS_MODE_CTRL 7'h02
`define AMS_OFS_MISC_CTRL 7'h02
`define AMS_OFS_DIAGNOSTIC_STATUS 7'h04
`define AMS_OFS_PORT_CTRL 7'h08
`define AMS_OFS_GLOBAL_CMD 7'h0a
`define AMS_OFS_SAMPLE_COUNT 7'h0a
`define AMS_OFS_PACKET_CTRL 7'h0c
`define AMS_OFS_TEMP_OUT 7'h0e
`define AMS_OFS_XACC_OUT 7'h10
`define AMS_OFS_YACC_OUT 7'h12
`define AMS_OFS_ZACC_OUT 7'h14
`define AMS_OFS_PAGE_SEL 7'h7e
// ==============================
// Field positions
`define AMS_MODE_CMD_HI 9
`define AMS_MODE_CMD_LO 8
`define AMS_MODE_STAT_BIT 10
`define AMS_SOFT_RST_BIT 7
`define AMS_AUTO_SEL_BIT 0
`define AMS_AUTO_START_BIT 1
`define AMS_COUNT_OUT_BIT 1
`define AMS_NOISE_SEL_BIT 4
`define AMS_READY_EN_BIT 2
`define AMS_READY_POL_BIT 1
`define AMS_EXT_SEL_BIT 6
`define AMS_TEST_LO 8
`define AMS_FLAG_EN_MASK 16'h8e00
`define AMS_SIGNAL_MASK 16'h8e10
`define AMS_MISC_KEEP_MASK 16'h0066
`define AMS_DIAG_ACC_BIT 1
`define AMS_DIAG_NVM_BIT 2
`define AMS_DIAG_VDD_BIT 8
`define AMS_DIAG_TEMP_BIT 9
`define AMS_DIAG_SENS_LO 10
// ==============================
// Mode commands
`define AMS_CMD_CONFIG 2'h1
`define AMS_CMD_SAMPLE 2'h2
`define AMS_CMD_SLEEP 2'h3
// ==============================
// Limits
`define AMS_ACC_MIN_MG 16'h0320
`define AMS_ACC_MAX_MG 16'h04b0
`define AMS_VDD_MIN_MV 16'h0bb8
`define AMS_VDD_MAX_MV 16'h0e10
// ==============================
// Times and derived cycle counts
`define AMS_TICK_NS 250000
`define AMS_TICK_CYC (`AMS_TICK_NS / `AMS_CLK_PERIOD_NS)
`define AMS_INIT_MS 970
`define AMS_INIT_CYC (`AMS_INIT_MS * 1000000 / `AMS_CLK_PERIOD_NS)
`define AMS_WAKE_MS 16
`define AMS_WAKE_CYC (`AMS_WAKE_MS * 1000000 / `AMS_CLK_PERIOD_NS)
`define AMS_TEST_MS 200
`define AMS_TEST_CYC (`AMS_TEST_MS * 1000000 / `AMS_CLK_PERIOD_NS)
`define AMS_NVM_TEST_MS 5
`define AMS_NVM_TEST_CYC (`AMS_NVM_TEST_MS * 1000000 / `AMS_CLK_PERIOD_NS)
`define AMS_SENSITIVITY_CHECK_START_S 40
`define AMS_SENSITIVITY_CHECK_START_CYC (64'd40 * 64'd1000000000 / `AMS_CLK_PERIOD_NS)
`define AMS_TICKS_PER_OUT 4
`endif

//--- core/ams_pkg.sv
package ams_pkg;
    // Operating state, Gray along init, config, sampling, sleep, wake
    typedef enum logic [2:0] {
        AMS_INIT = 3'h0,
        AMS_CONFIG = 3'h1,
        AMS_SAMPLE = 3'h3,
        AMS_SLEEP = 3'h2,
        AMS_WAKE = 3'h6
    } ams_state_t;
    // Register access from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [15:0] wdata;
    } ams_reg_req_t;
    // Measurements used by the self tests
    typedef struct packed {
        logic [15:0] accel_mag_mg;
        logic [15:0] supply_mv;
        logic temp_ok;
        logic nvm_ok;
        logic [1:0] sens_result;
    } ams_sense_t;
endpackage

//--- core/ams_mode_ready.sv
`timescale 1ns/10ps
`include "ams_consts.svh"
// What this block does
// - Init after reset, then config or auto-sampling
// - Mode command field switches operating mode
// - Software reset reruns init, then config or auto-sampling
// - Sampling mode ignores most register writes
// - Auto-sampling bit sends packets unrequested
// - Sleep halts circuits; trigger edge wakes
// - Noise-floor select sets measurement condition
// - Ready sets on new data, clears on read
// - Auto mode clears ready flags as each packet starts
// - Ready pin gated by enable, polarity selectable
// - Ready is OR of enabled new-sample flags
// - Counter increments every 250 microseconds while circuits run
// - Count-out bit adds counter to packets
// - Accel check passes between 0.8 and 1.2 G
// - Sensitivity checks, 40 s, report bits 11:10
// - Temperature check reports diagnostic bit 9
// - Supply check 3.0 to 3.6 V, bit 8
// - Memory consistency check reports bit 2
// - Pin carries ready only when enabled
module ams_mode_ready #(
    parameter int unsigned TICK_CYC = `AMS_TICK_CYC,
    parameter int unsigned INIT_CYC = `AMS_INIT_CYC,
    parameter int unsigned WAKE_CYC = `AMS_WAKE_CYC,
    parameter int unsigned TEST_CYC = `AMS_TEST_CYC,
    parameter int unsigned NVM_TEST_CYC = `AMS_NVM_TEST_CYC,
    parameter longint unsigned SENSITIVITY_CHECK_START_CYC = `AMS_SENSITIVITY_CHECK_START_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register access
    input ams_pkg::ams_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    // Pins and measurements
    input wire logic ext_trig_pin,
    input ams_pkg::ams_sense_t sense,
    // Outputs
    output logic sample_ready_pin,
    output logic pkt_start,
    output logic pkt_with_count,
    output logic noise_floor_reduced,
    output logic circuit_active
);
    // ==============================
    // State and registers
    ams_pkg::ams_state_t state; // Operating state
    logic [31:0] init_cnt; // Init / wake timer
    logic [15:0] signal_control; // Flag enables, noise select
    logic [15:0] misc_control; // Ready pin, trigger, test starts
    logic [15:0] diagnostic_status; // Test results
    logic [15:0] serial_port_control; // Auto sampling, auto start
    logic [15:0] packet_content_control; // Packet content
    logic [7:0] register_page_id; // Register window
    logic [15:0] sample_counter; // Tick count, held in init, sleep and wake
    logic [31:0] tick_cnt; // 250 us divider
    logic [1:0] out_cnt; // Ticks per output sample
    logic [3:0] new_sample_flag; // Temp, X, Y, Z
    logic [63:0] test_cnt; // Self-test timer
    logic [2:0] test_idx; // Running test, 0..6
    logic test_busy;
    logic test_done; // Running test in its last cycle
    logic [2:0] trig_sync; // Sync pair plus edge history
    // ==============================
    // Decode
    logic page1, wr_ok, tick, out_done, trig_edge, sampling, auto_on;
    logic [3:0] flag_read;
    assign page1 = register_page_id[0];
    assign sampling = (state == ams_pkg::AMS_SAMPLE);
    assign auto_on = serial_port_control[`AMS_AUTO_SEL_BIT];
    // Full writes only outside sampling mode
    assign wr_ok = reg_req.wr && !sampling;
    assign tick = circuit_active && (tick_cnt == TICK_CYC - 1);
    assign out_done = sampling && tick && (out_cnt == 2'(`AMS_TICKS_PER_OUT - 1));
    assign trig_edge = trig_sync[1] ^ trig_sync[2];

    // Address match within the current window
    function automatic logic hit(input logic [6:0] a, input logic w1, input logic [6:0] ofs);
        hit = (a == ofs) && (page1 == w1);
    endfunction

    // Reads of sensor outputs clear matching flags
    always_comb begin
        flag_read[3] = reg_req.rd && hit(reg_req.addr, 1'b0, `AMS_OFS_TEMP_OUT);
        flag_read[2] = reg_req.rd && hit(reg_req.addr, 1'b0, `AMS_OFS_XACC_OUT);
        flag_read[1] = reg_req.rd && hit(reg_req.addr, 1'b0, `AMS_OFS_YACC_OUT);
        flag_read[0] = reg_req.rd && hit(reg_req.addr, 1'b0, `AMS_OFS_ZACC_OUT);
    end

    // Soft reset accepted in every mode, mode commands in config and sampling
    logic mode_wr, soft_rst;
    assign mode_wr = reg_req.wr && hit(reg_req.addr, 1'b0, `AMS_OFS_MODE_CTRL);
    assign soft_rst = reg_req.wr && hit(reg_req.addr, 1'b1, `AMS_OFS_GLOBAL_CMD)
                      && reg_req.wdata[`AMS_SOFT_RST_BIT];

    // ==============================
    // Trigger pin synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_sync <= 3'h0;
        end else begin
            trig_sync <= {trig_sync[1:0], ext_trig_pin};
        end
    end

    // ==============================
    // Operating state machine
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ams_pkg::AMS_INIT;
            init_cnt <= 32'h0;
        end else if (soft_rst) begin
            state <= ams_pkg::AMS_INIT;
            init_cnt <= 32'h0;
        end else begin
            case (state)
                ams_pkg::AMS_INIT, ams_pkg::AMS_WAKE: begin
                    init_cnt <= init_cnt + 32'h1;
                    if (state == ams_pkg::AMS_WAKE && init_cnt >= WAKE_CYC - 1) begin
                        state <= ams_pkg::AMS_CONFIG;
                    end else if (state == ams_pkg::AMS_INIT && init_cnt >= INIT_CYC - 1) begin
                        // Auto start only with auto sampling
                        if (auto_on && serial_port_control[`AMS_AUTO_START_BIT]) begin
                            state <= ams_pkg::AMS_SAMPLE;
                        end else begin
                            state <= ams_pkg::AMS_CONFIG;
                        end
                    end
                end
                ams_pkg::AMS_CONFIG, ams_pkg::AMS_SAMPLE: begin
                    if (mode_wr) begin
                        case (reg_req.wdata[`AMS_MODE_CMD_HI:`AMS_MODE_CMD_LO])
                            `AMS_CMD_CONFIG: state <= ams_pkg::AMS_CONFIG;
                            `AMS_CMD_SAMPLE: state <= ams_pkg::AMS_SAMPLE;
                            `AMS_CMD_SLEEP: state <= ams_pkg::AMS_SLEEP;
                            default: state <= state;
                        endcase
                    end
                end
                ams_pkg::AMS_SLEEP: begin
                    init_cnt <= 32'h0;
                    if (trig_edge) begin
                        state <= ams_pkg::AMS_WAKE;
                    end
                end
                default: state <= ams_pkg::AMS_INIT;
            endcase
        end
    end

    // Circuits run except in init, sleep and wake
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            circuit_active <= 1'b0;
        end else begin
            circuit_active <= !soft_rst && (state == ams_pkg::AMS_CONFIG || sampling);
        end
    end

    // ==============================
    // Configuration registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            signal_control <= 16'h0;
            serial_port_control <= 16'h0;
            packet_content_control <= 16'h0;
            register_page_id <= 8'h0;
        end else begin
            if (reg_req.wr && reg_req.addr == `AMS_OFS_PAGE_SEL) begin
                register_page_id <= reg_req.wdata[7:0];
            end
            if (wr_ok && hit(reg_req.addr, 1'b1, `AMS_OFS_SIGNAL_CTRL)) begin
                signal_control <= reg_req.wdata & `AMS_SIGNAL_MASK;
            end
            if (wr_ok && hit(reg_req.addr, 1'b1, `AMS_OFS_PORT_CTRL)) begin
                serial_port_control <= reg_req.wdata & 16'h0003;
            end
            if (wr_ok && hit(reg_req.addr, 1'b1, `AMS_OFS_PACKET_CTRL)) begin
                packet_content_control <= reg_req.wdata & 16'h0003;
            end
        end
    end

    // Misc control; test start bits stay set while running
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_control <= 16'h0;
        end else begin
            if (wr_ok && hit(reg_req.addr, 1'b1, `AMS_OFS_MISC_CTRL)) begin
                misc_control <= (reg_req.wdata & `AMS_MISC_KEEP_MASK)
                                | (reg_req.wdata & 16'h7f00) | (misc_control & 16'h7f00);
            end
            if (test_busy && test_done) begin
                misc_control[`AMS_TEST_LO + test_idx] <= 1'b0;
            end
        end
    end

    // ==============================
    // Self-test engine, lowest pending test first
    logic [6:0] pend;
    logic [2:0] next_idx;
    assign pend = misc_control[14:8];
    assign test_done = (test_cnt == 64'h0);
    always_comb begin
        next_idx = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (pend[i]) begin
                next_idx = 3'(i);
            end
        end
    end

    // Test duration by test index
    function automatic logic [63:0] test_len(input logic [2:0] idx);
        case (idx)
            3'h3: test_len = 64'(NVM_TEST_CYC) - 64'h1;
            3'h4, 3'h5, 3'h6: test_len = SENSITIVITY_CHECK_START_CYC - 64'h1;
            default: test_len = 64'(TEST_CYC) - 64'h1;
        endcase
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            test_busy <= 1'b0;
            test_idx <= 3'h0;
            test_cnt <= 64'h0;
        end else if (!test_busy) begin
            if (|pend && circuit_active) begin
                test_busy <= 1'b1;
                test_idx <= next_idx;
                test_cnt <= test_len(next_idx);
            end
        end else if (test_done) begin
            test_busy <= 1'b0;
        end else begin
            test_cnt <= test_cnt - 64'h1;
        end
    end

    // Result latch at test completion
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            diagnostic_status <= 16'h0;
        end else if (test_busy && test_done) begin
            case (test_idx)
                3'h0: diagnostic_status[`AMS_DIAG_VDD_BIT] <=
                    (sense.supply_mv < `AMS_VDD_MIN_MV) || (sense.supply_mv > `AMS_VDD_MAX_MV);
                3'h1: diagnostic_status[`AMS_DIAG_TEMP_BIT] <= !sense.temp_ok;
                3'h2: diagnostic_status[`AMS_DIAG_ACC_BIT] <=
                    (sense.accel_mag_mg < `AMS_ACC_MIN_MG)
                    || (sense.accel_mag_mg > `AMS_ACC_MAX_MG);
                3'h3: diagnostic_status[`AMS_DIAG_NVM_BIT] <= !sense.nvm_ok;
                default: diagnostic_status[`AMS_DIAG_SENS_LO +: 2] <= sense.sens_result;
            endcase
        end
    end

    // ==============================
    // Sample timing and counter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 32'h0;
            sample_counter <= 16'h0;
            out_cnt <= 2'h0;
        end else if (!circuit_active) begin
            tick_cnt <= 32'h0;
            out_cnt <= 2'h0;
        end else if (tick) begin
            tick_cnt <= 32'h0;
            sample_counter <= sample_counter + 16'h1;
            out_cnt <= sampling ? out_cnt + 2'h1 : 2'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    // ==============================
    // New-sample flags and packet start
    logic sample_new;
    assign sample_new = misc_control[`AMS_EXT_SEL_BIT] ? (sampling && trig_edge) : out_done;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            new_sample_flag <= 4'h0;
            pkt_start <= 1'b0;
        end else begin
            pkt_start <= 1'b0;
            if (auto_on && sampling && |new_sample_flag) begin
                new_sample_flag <= 4'h0;
                pkt_start <= 1'b1;
            end else begin
                // Set wins over a same-cycle read
                new_sample_flag <= (new_sample_flag & ~flag_read)
                    | ({4{sample_new}} & {signal_control[15], signal_control[11:9]});
            end
        end
    end

    // Ready pin, packet content, noise floor
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_ready_pin <= 1'b0;
            pkt_with_count <= 1'b0;
            noise_floor_reduced <= 1'b0;
        end else begin
            sample_ready_pin <= misc_control[`AMS_READY_EN_BIT]
                && ((|new_sample_flag) ^ !misc_control[`AMS_READY_POL_BIT]);
            pkt_with_count <= packet_content_control[`AMS_COUNT_OUT_BIT];
            noise_floor_reduced <= sampling && signal_control[`AMS_NOISE_SEL_BIT];
        end
    end

    // ==============================
    // Register read data, one cycle after the read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0;
        end else if (reg_req.rd) begin
            if (reg_req.addr == `AMS_OFS_PAGE_SEL) reg_rdata <= {8'h0, register_page_id};
            else if (hit(reg_req.addr, 1'b0, `AMS_OFS_MODE_CTRL))
                reg_rdata <= 16'(sampling) << `AMS_MODE_STAT_BIT;
            else if (hit(reg_req.addr, 1'b0, `AMS_OFS_DIAGNOSTIC_STATUS)) reg_rdata <= diagnostic_status;
            else if (hit(reg_req.addr, 1'b0, `AMS_OFS_SAMPLE_COUNT)) reg_rdata <= sample_counter;
            else if (hit(reg_req.addr, 1'b1, `AMS_OFS_SIGNAL_CTRL)) reg_rdata <= signal_control;
            else if (hit(reg_req.addr, 1'b1, `AMS_OFS_MISC_CTRL)) reg_rdata <= misc_control;
            else if (hit(reg_req.addr, 1'b1, `AMS_OFS_PORT_CTRL)) reg_rdata <= serial_port_control;
            else if (hit(reg_req.addr, 1'b1, `AMS_OFS_PACKET_CTRL))
                reg_rdata <= packet_content_control;
            else reg_rdata <= 16'h0;
        end
    end

    // ==============================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence cfg_write_s;
        reg_req.wr && sampling && hit(reg_req.addr, 1'b1, `AMS_OFS_SIGNAL_CTRL);
    endsequence
    sequence auto_new_s;
        auto_on && sampling && (|new_sample_flag);
    endsequence
    mode_sleep_cmd_a: assert property (mode_wr && !soft_rst
        && state == ams_pkg::AMS_CONFIG
        && reg_req.wdata[9:8] == `AMS_CMD_SLEEP |=> state == ams_pkg::AMS_SLEEP)
        else $error("Sleep command not taken");
    soft_reset_init_a: assert property (soft_rst
        |=> state == ams_pkg::AMS_INIT ##1 !circuit_active)
        else $error("Soft reset did not restart init");
    sample_write_lock_a: assert property (cfg_write_s |=> $stable(signal_control))
        else $error("Write accepted in sampling mode");
    sleep_wake_a: assert property (state == ams_pkg::AMS_SLEEP && trig_edge
        && !soft_rst |=> state == ams_pkg::AMS_WAKE)
        else $error("Trigger edge did not wake");
    auto_packet_a: assert property (auto_new_s |=> pkt_start && new_sample_flag == 4'h0)
        else $error("Ready not dropped at packet start");
    ready_pin_off_a: assert property (!misc_control[`AMS_READY_EN_BIT]
        |=> !sample_ready_pin)
        else $error("Ready pin driven while disabled");
    ready_pin_pol_a: assert property (misc_control[2] && misc_control[1]
        && $stable(misc_control) |=> sample_ready_pin == $past(|new_sample_flag))
        else $error("Ready pin polarity wrong");
    no_enable_ready_a: assert property (signal_control[15] == 1'b0
        && signal_control[11:9] == 3'h0 && new_sample_flag == 4'h0 |=> new_sample_flag == 4'h0)
        else $error("Ready rose with no flag enabled");
    flag_read_clear_a: assert property (!sample_new && !auto_on && flag_read[0]
        |=> !new_sample_flag[0])
        else $error("Read did not clear flag");
    count_step_a: assert property (tick
        |=> sample_counter == $past(sample_counter) + 16'h1)
        else $error("Counter did not step");
    test_self_clear_a: assert property (test_busy && test_done
        |=> !test_busy && !misc_control[`AMS_TEST_LO + test_idx])
        else $error("Test start bit not cleared");
    acc_result_a: assert property (test_busy && test_done && test_idx == 3'h2
        && sense.accel_mag_mg > `AMS_ACC_MAX_MG |=> diagnostic_status[1])
        else $error("Accel check failure not flagged");
endmodule

//--- dv/ams_host_model.sv
`timescale 1ns/10ps
// ==============================
// Host side of the register path
module ams_host_model (
    // Clock
    input wire logic core_clk,
    // Register path
    output ams_pkg::ams_reg_req_t reg_req,
    input wire logic [15:0] reg_rdata
);
    // Idle bus from time zero
    initial reg_req = '0;

    // One-cycle write strobe, mode changes go through here
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        reg_req.wr <= 1'b0;
    endtask

    // One-cycle read, data taken once it has settled
    // Manual sampling only, and no reads while auto packets flow
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge core_clk);
        reg_req.rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
endmodule

//--- dv/accel_mode_ready_selftest_bench.sv
`timescale 1ns/10ps
// ==============================
// Bench for mode, ready and self-test control
module accel_mode_ready_selftest_bench;
    // Stimulus
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ext_trig_pin = 1'b0;
    ams_pkg::ams_sense_t sense = '0;
    // Observed
    ams_pkg::ams_reg_req_t reg_req;
    logic [15:0] reg_rdata;
    logic sample_ready_pin, pkt_start, pkt_with_count, noise_floor_reduced, circuit_active;
    // Expected reads as mask and value
    logic [31:0] exp_q[$];
    logic rd_pend = 1'b0;
    int errors = 0;
    int cmp_count = 0;
    logic [15:0] v, c0;
    int unsigned acc, vdd, flg;

    initial forever #5 core_clk = ~core_clk;

    ams_mode_ready #(.TICK_CYC(10), .INIT_CYC(20), .WAKE_CYC(8), .TEST_CYC(16),
        .NVM_TEST_CYC(4), .SENSITIVITY_CHECK_START_CYC(12)) ams_mode_ready_i (
        .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .ext_trig_pin(ext_trig_pin), .sense(sense), .sample_ready_pin(sample_ready_pin),
        .pkt_start(pkt_start), .pkt_with_count(pkt_with_count),
        .noise_floor_reduced(noise_floor_reduced), .circuit_active(circuit_active));
    ams_host_model ams_host_model_i (.core_clk(core_clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata));

    // ==============================
    // Read watcher: oldest note against settled read data
    always @(posedge core_clk) rd_pend <= reg_req.rd;
    always @(negedge core_clk) begin
        if (rd_pend && exp_q.size() > 0) begin
            chk_reg(exp_q.pop_front());
        end
    end

    task automatic report(input string m);
        errors++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task automatic chk_reg(input logic [31:0] e);
        cmp_count++;
        if ((reg_rdata & e[31:16]) !== (e[15:0] & e[31:16])) report("register read");
    endtask
    task automatic chk_bit(input logic act, input logic exp);
        cmp_count++;
        if (act !== exp) report("output flag");
    endtask
    task automatic rdc(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back({m, e});
        ams_host_model_i.rd(a, v);
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        ams_host_model_i.wr(a, d);
    endtask
    // Bounded wait: 0 active, 1 ready pin, 2 packet start
    task automatic wait_for(input int w, input int lim);
        int n;
        n = 0;
        while (!(w == 0 ? circuit_active === 1'b1 :
                 w == 1 ? sample_ready_pin === 1'b1 : pkt_start === 1'b1)) begin
            @(negedge core_clk);
            n++;
            if (n > lim) begin
                report("timeout");
                summarize();
            end
        end
    endtask
    task automatic summarize();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ==============================
    // Main sequence
    initial begin
        void'($urandom(32'hcc7e5464));
        acc = 600 + $urandom % 800;
        vdd = 2800 + $urandom % 1000;
        flg = $urandom;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_for(0, 60);
        rdc(7'h40, 16'h0000, 16'hffff);
        // Page 1: flag enables, noise select, pin off / active low / active high
        wr(7'h7e, 16'h0001);
        wr(7'h00, 16'h8e10);
        for (int i = 0; i < 3; i++) begin
            wr(7'h02, 16'(2 * (i + 1)));
            repeat (3) @(negedge core_clk);
            chk_bit(sample_ready_pin, i == 1);
        end
        // All self tests at once, random sense inputs; flags follow the trigger pin from here
        @(posedge core_clk);
        sense <= '{accel_mag_mg: acc[15:0], supply_mv: vdd[15:0], temp_ok: flg[2],
            nvm_ok: flg[3], sens_result: flg[1:0]};
        wr(7'h02, 16'h7f46);
        rdc(7'h02, 16'h7f00, 16'h7f00);
        for (int n = 0; n < 60 && v[14:8] != 7'h00; n++) rdc(7'h02, 16'h0000, 16'h0000);
        chk_bit(v[14:8] == 7'h00, 1'b1);
        wr(7'h7e, 16'h0000);
        v = 16'h0000;
        v[11:10] = flg[1:0];
        v[9] = !flg[2];
        v[2] = !flg[3];
        v[8] = vdd < 3000 || vdd > 3600;
        v[1] = acc < 800 || acc > 1200;
        rdc(7'h04, v, 16'h0f06);
        // Sampling, locked writes, counter
        wr(7'h02, 16'h0200);
        rdc(7'h02, 16'h0400, 16'h0400);
        chk_bit(noise_floor_reduced, 1'b1);
        wr(7'h7e, 16'h0001);
        wr(7'h00, 16'h0000);
        rdc(7'h00, 16'h8e10, 16'hffff);
        wr(7'h7e, 16'h0000);
        ams_host_model_i.rd(7'h0a, c0);
        repeat (98) @(posedge core_clk);
        rdc(7'h0a, c0 + 16'd10, 16'hffff);
        // Ready holds until every enabled value is read
        @(posedge core_clk);
        ext_trig_pin <= 1'b1;
        wait_for(1, 80);
        for (int i = 0; i < 3; i++) ams_host_model_i.rd(7'(7'h0e + 2 * i), v);
        chk_bit(sample_ready_pin, 1'b1);
        ams_host_model_i.rd(7'h14, v);
        @(negedge core_clk);
        chk_bit(sample_ready_pin, 1'b0);
        // Auto start after soft reset, packets with count
        wr(7'h02, 16'h0100);
        wr(7'h7e, 16'h0001);
        wr(7'h08, 16'h0003);
        wr(7'h0c, 16'h0002);
        repeat (2) @(negedge core_clk);
        chk_bit(pkt_with_count, 1'b1);
        wr(7'h0a, 16'h0080);
        repeat (2) @(negedge core_clk);
        chk_bit(circuit_active, 1'b0);
        wait_for(0, 60);
        @(posedge core_clk);
        ext_trig_pin <= 1'b0;
        wait_for(2, 80);
        chk_bit(sample_ready_pin, 1'b1);
        @(negedge core_clk);
        chk_bit(sample_ready_pin, 1'b0);
        // Back to config, plain soft reset lands in config
        wr(7'h7e, 16'h0000);
        wr(7'h02, 16'h0100);
        wr(7'h7e, 16'h0001);
        wr(7'h08, 16'h0000);
        wr(7'h0a, 16'h0080);
        repeat (2) @(negedge core_clk);
        wait_for(0, 60);
        wr(7'h7e, 16'h0000);
        rdc(7'h02, 16'h0000, 16'h0400);
        // Sleep, then trigger edge wakes
        wr(7'h02, 16'h0300);
        repeat (2) @(negedge core_clk);
        chk_bit(circuit_active, 1'b0);
        @(posedge core_clk);
        ext_trig_pin <= 1'b1;
        wait_for(0, 40);
        summarize();
    end
endmodule
